//--- pwt_timing.sv
// Purpose: Switching clock select and gate on/off timing of a PWM controller
// Assumes: 100 MHz system clock; sync pin clock unrelated; pins asynchronous
// Notes:   Peak current compare arrives as a digital trip pin
//
// Overview of operation
// - Run synchronized when an external clock is detected, else internal.
// - Internal oscillator period follows the resistor setting, 100 kHz-1 MHz.
// - In sync mode each cycle starts on an external edge, one per period.
// - A newly applied external clock is adopted within a few of its cycles.
// - A lost external clock is detected within a few cycles, then internal.
// - The sync pin is input only and is never driven.
// - Full-duty variant may hold the gate on for a whole period.
// - Half-duty variant limits gate on-time to half of each period.
// - Once on, the gate stays on at least the minimum on-time.
// - Once off by PWM action, the gate stays off the minimum off-time.
// - A cycle start during minimum off-time turns on when it elapses.
// - No switching until all start-up conditions hold; then soft start.
// - Gate turns on at the clock edge and off at the current trip.
`timescale 1ns/1ps
`include "pwt_cfg.svh"

module pwt_timing
#(
  parameter bit FULL_DUTY = 1'b1,
  parameter int PERIOD_W  = 10
)
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                i_sync_clk,
  input  wire pwt_pkg::pwt_start_t i_start,
  input  wire logic [PERIOD_W-1:0] i_freq_resistor_pin,
  input  wire logic                i_peak_trip,
  output logic                     o_gate,
  output logic                     o_sync_mode,
  output logic                     o_soft_start
);

  localparam logic [15:0] MIN_ON  = 16'(`PWT_MIN_ON_CYC);
  localparam logic [15:0] MIN_OFF = 16'(`PWT_MIN_OFF_CYC);
  localparam logic [PERIOD_W-1:0] PER_MIN = PERIOD_W'(`PWT_PER_MIN_CYC);
  localparam logic [PERIOD_W-1:0] PER_MAX = PERIOD_W'(`PWT_PER_MAX_CYC);
  localparam int OFF_WAIT = `PWT_MIN_OFF_CYC + 1;

  if ((2 ** PERIOD_W) <= `PWT_PER_MAX_CYC || PERIOD_W > 14)
  begin : g_width_check
    $error("PERIOD_W cannot hold the longest switching period");
  end

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  pwt_pkg::pwt_start_t      start_meta;
  pwt_pkg::pwt_start_t      start_s;
  logic [PERIOD_W-1:0]      freq_meta;
  logic [PERIOD_W-1:0]      freq_s;
  logic                     trip_meta;
  logic                     trip_s;
  logic                     run;
  logic                     run_d;
  logic [PERIOD_W-1:0]      per;
  logic [PERIOD_W-1:0]      osc_cnt;
  logic                     osc_wrap;
  logic                     ext_edge;
  logic                     det_mode;
  logic                     mode_d;
  logic [PERIOD_W-1:0]      ext_per;
  logic                     cycle_start;
  logic [PERIOD_W-1:0]      max_on_p;
  logic [15:0]              max_on;
  logic                     at_limit;
  pwt_pkg::pwt_state_t      st;
  logic [15:0]              cnt;
  logic                     pend;
  logic [15:0]              hi_cnt;
  logic [15:0]              lo_cnt;

  // Pin inputs pass two flip-flops before any logic reads them
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      start_meta <= '0;
      start_s    <= '0;
      freq_meta  <= '0;
      freq_s     <= '0;
      trip_meta  <= 1'b0;
      trip_s     <= 1'b0;
    end
    else
    begin
      start_meta <= i_start;
      start_s    <= start_meta;
      freq_meta  <= i_freq_resistor_pin;
      freq_s     <= freq_meta;
      trip_meta  <= i_peak_trip;
      trip_s     <= trip_meta;
    end
  end

  // All lockouts clear, reference up, enabled and not overheated
  assign run = start_s.vin_ok && start_s.pvin_ok && start_s.vldo_ok
               && start_s.ref_ok && start_s.enable
               && !start_s.therm_sd;

  // Soft start is launched once, the cycle after the conditions come true
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      run_d        <= 1'b0;
      o_soft_start <= 1'b0;
    end
    else
    begin
      run_d        <= run;
      o_soft_start <= run && !run_d;
    end
  end

  // Out-of-range settings are clamped to the supported frequency span
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      per <= PER_MAX;
    else if (freq_s < PER_MIN)
      per <= PER_MIN;
    else if (freq_s > PER_MAX)
      per <= PER_MAX;
    else
      per <= freq_s;
  end

  pwt_sync_det
  #(
    .PERIOD_W (PERIOD_W)
  )
  u_sync_det
  (
    .i_sys_clk    (i_sys_clk),
    .i_rst        (i_rst),
    .i_sync_clk   (i_sync_clk),
    .i_period     (per),
    .o_edge       (ext_edge),
    .o_sync_mode  (det_mode),
    .o_ext_period (ext_per)
  );

  assign o_sync_mode = det_mode;

  // Held at zero in sync mode so that a fallback starts a fresh period
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      osc_cnt <= '0;
    else if (det_mode || osc_wrap)
      osc_cnt <= '0;
    else
      osc_cnt <= osc_cnt + PERIOD_W'(1);
  end

  assign osc_wrap = !det_mode && (osc_cnt >= per - PERIOD_W'(1));

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      mode_d <= 1'b0;
    else
      mode_d <= det_mode;
  end

  // One switching cycle per external edge, in phase with it
  assign cycle_start = det_mode ? ext_edge : osc_wrap;

  // Half of the running period; in sync mode the measured one is used,
  // so an external duty far from half still caps at half the period
  assign max_on_p = (det_mode ? ext_per : per) >> 1;
  assign max_on   = {{(16 - PERIOD_W){1'b0}}, max_on_p};
  assign at_limit = !FULL_DUTY && (cnt >= max_on);

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st     <= pwt_pkg::PWT_ST_DIS;
      cnt    <= '0;
      pend   <= 1'b0;
      o_gate <= 1'b0;
    end
    else if (!run)
    begin
      st     <= pwt_pkg::PWT_ST_DIS;
      cnt    <= '0;
      pend   <= 1'b0;
      o_gate <= 1'b0;
    end
    else
    begin
      case (st)
        pwt_pkg::PWT_ST_DIS:
        begin
          st <= pwt_pkg::PWT_ST_IDLE;
        end
        pwt_pkg::PWT_ST_IDLE:
        begin
          if (cycle_start)
          begin
            o_gate <= 1'b1;
            cnt    <= 16'h0001;
            st     <= pwt_pkg::PWT_ST_ON_MIN;
          end
        end
        pwt_pkg::PWT_ST_ON_MIN:
        begin
          // Trip is blind here, as if blanked, until the on-time is met
          cnt <= sat_inc(cnt);
          if (cnt >= MIN_ON - 16'h0001)
            st <= pwt_pkg::PWT_ST_ON;
        end
        pwt_pkg::PWT_ST_ON:
        begin
          cnt <= sat_inc(cnt);
          if (trip_s || at_limit)
          begin
            o_gate <= 1'b0;
            cnt    <= 16'h0001;
            pend   <= 1'b0;
            st     <= pwt_pkg::PWT_ST_OFF_MIN;
          end
          // Full duty: a new cycle start leaves the gate on
          else if (FULL_DUTY && cycle_start)
            cnt <= 16'h0001;
        end
        pwt_pkg::PWT_ST_OFF_MIN:
        begin
          cnt <= sat_inc(cnt);
          if (cycle_start)
            pend <= 1'b1;
          if (cnt >= MIN_OFF)
          begin
            pend <= 1'b0;
            if (pend || cycle_start)
            begin
              o_gate <= 1'b1;
              cnt    <= 16'h0001;
              st     <= pwt_pkg::PWT_ST_ON_MIN;
            end
            else
              st <= pwt_pkg::PWT_ST_IDLE;
          end
        end
        default:
        begin
          st     <= pwt_pkg::PWT_ST_DIS;
          o_gate <= 1'b0;
        end
      endcase
    end
  end

  // Lengths of the present high and low runs of the gate
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hi_cnt <= '0;
      lo_cnt <= '0;
    end
    else
    begin
      hi_cnt <= o_gate ? sat_inc(hi_cnt) : 16'h0000;
      lo_cnt <= o_gate ? 16'h0000 : sat_inc(lo_cnt);
    end
  end

  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  min_on_time_a: assert property (
    $fell(o_gate) && run_d |-> hi_cnt >= MIN_ON)
    else $error("gate on shorter than minimum on-time");

  min_off_time_a: assert property (
    $rose(o_gate) |-> lo_cnt >= MIN_OFF)
    else $error("gate off shorter than minimum off-time");

  half_duty_cap_a: assert property (
    (!FULL_DUTY && o_gate) |-> hi_cnt <= max_on)
    else $error("half duty gate on beyond half period");

  delayed_turnon_a: assert property (
    (run && st == pwt_pkg::PWT_ST_OFF_MIN && cycle_start)
      |-> ##[1:OFF_WAIT] (o_gate || !run))
    else $error("deferred turn-on lost after minimum off-time");

  edge_turnon_a: assert property (
    (run && st == pwt_pkg::PWT_ST_IDLE && cycle_start) |=> o_gate)
    else $error("gate did not turn on at cycle start");

  trip_turnoff_a: assert property (
    (run && st == pwt_pkg::PWT_ST_ON && trip_s) |=> !o_gate)
    else $error("gate did not turn off on current trip");

  // In sync mode an idle gate may only rise on an external edge
  sync_phase_a: assert property (
    (run && det_mode && st == pwt_pkg::PWT_ST_IDLE && !ext_edge)
      |=> !o_gate)
    else $error("gate started without an external edge");

  full_hold_a: assert property (
    (FULL_DUTY && run && st == pwt_pkg::PWT_ST_ON && !trip_s)
      |=> o_gate)
    else $error("full duty gate dropped without a trip");

  startup_gate_a: assert property (
    !run |=> !o_gate)
    else $error("gate switching before start-up conditions");

  osc_period_a: assert property (
    (!det_mode && !mode_d && $past(osc_wrap)) |-> osc_cnt == '0)
    else $error("internal oscillator period not restarted");

  period_clamp_a: assert property (
    per >= PER_MIN && per <= PER_MAX)
    else $error("internal period outside supported span");

  soft_start_a: assert property (
    $rose(run) |=> o_soft_start)
    else $error("soft start not launched when start-up completes");

  soft_pulse_a: assert property (
    o_soft_start |=> !o_soft_start)
    else $error("soft start strobe longer than one cycle");

endmodule

//--- pwt_cfg.svh
// Purpose: Timing constants for the PWM timing and clock select block
// Assumes: System clock of 100 MHz
// Notes:   Cycle counts are derived here from the printed times and rates
`ifndef PWT_CFG_SVH
`define PWT_CFG_SVH

`define PWT_CLK_MHZ      100
`define PWT_MIN_ON_NS    120
`define PWT_MIN_OFF_NS   40
`define PWT_FSW_MIN_KHZ  100
`define PWT_FSW_MAX_KHZ  1000

// Least times round up to whole cycles
`define PWT_MIN_ON_CYC  ((`PWT_MIN_ON_NS * `PWT_CLK_MHZ + 999) / 1000)
`define PWT_MIN_OFF_CYC ((`PWT_MIN_OFF_NS * `PWT_CLK_MHZ + 999) / 1000)
`define PWT_PER_MIN_CYC ((`PWT_CLK_MHZ * 1000) / `PWT_FSW_MAX_KHZ)
`define PWT_PER_MAX_CYC ((`PWT_CLK_MHZ * 1000) / `PWT_FSW_MIN_KHZ)

// External clock detection, in edges and in programmed periods
`define PWT_ACQ_EDGES    3
`define PWT_ACQ_PERIODS  2
`define PWT_LOSS_PERIODS 3

`endif

//--- pwt_pkg.sv
// Purpose: Types shared by the PWM timing and clock select block
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Constants live in pwt_cfg.svh
package pwt_pkg;

  typedef enum logic [2:0]
  {
    PWT_ST_DIS     = 3'b000,
    PWT_ST_IDLE    = 3'b001,
    PWT_ST_ON_MIN  = 3'b010,
    PWT_ST_ON      = 3'b011,
    PWT_ST_OFF_MIN = 3'b100
  } pwt_state_t;

  typedef struct packed
  {
    logic vin_ok;
    logic pvin_ok;
    logic vldo_ok;
    logic ref_ok;
    logic enable;
    logic therm_sd;
  } pwt_start_t;

endpackage

//--- pwt_sync_det.sv
// Purpose: Detects an external clock on the sync pin and marks its edges
// Assumes: Sync pin clock may stop at any time
// Notes:   Edges cross as a toggle; loss is timed in the system domain
`timescale 1ns/1ps
`include "pwt_cfg.svh"

module pwt_sync_det
#(
  parameter int PERIOD_W = 10
)
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                i_sync_clk,
  input  wire logic [PERIOD_W-1:0] i_period,
  output logic                     o_edge,
  output logic                     o_sync_mode,
  output logic [PERIOD_W-1:0]      o_ext_period
);

  localparam int GW = PERIOD_W + 2;

  logic          link_tgl;
  logic          meta;
  logic          sync_a;
  logic          sync_b;
  logic          edge_hit;
  logic [GW-1:0] gap;
  logic [GW-1:0] loss_lim;
  logic [GW-1:0] acq_win;
  logic [1:0]    acq;
  logic          mode;

  // The pin is only ever sampled as a clock; nothing here drives it
  always_ff @(posedge i_sync_clk or posedge i_rst)
  begin
    if (i_rst)
      link_tgl <= 1'b0;
    else
      link_tgl <= ~link_tgl;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta   <= 1'b0;
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      meta   <= link_tgl;
      sync_a <= meta;
      sync_b <= sync_a;
    end
  end

  assign edge_hit = sync_a ^ sync_b;
  assign loss_lim = GW'(`PWT_LOSS_PERIODS) * {2'b00, i_period};
  assign acq_win  = GW'(`PWT_ACQ_PERIODS) * {2'b00, i_period};

  // Cycles since the last edge, saturating at the loss limit
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      gap <= '1;
    else if (edge_hit)
      gap <= GW'(1);
    else if (gap < loss_lim)
      gap <= gap + GW'(1);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode <= 1'b0;
      acq  <= 2'h0;
    end
    else if (!mode)
    begin
      if (edge_hit && gap <= acq_win)
      begin
        if (acq == 2'(`PWT_ACQ_EDGES - 2))
        begin
          mode <= 1'b1;
          acq  <= 2'h0;
        end
        else
          acq <= acq + 2'h1;
      end
      else if (edge_hit || gap >= loss_lim)
        acq <= 2'h0;
    end
    else if (gap >= loss_lim)
      mode <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_edge       <= 1'b0;
      o_ext_period <= '0;
    end
    else
    begin
      o_edge <= edge_hit;
      if (edge_hit)
        o_ext_period <= (gap[GW-1:PERIOD_W] != 2'b00) ? '1
                                                      : gap[PERIOD_W-1:0];
    end
  end

  assign o_sync_mode = mode;

  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sync_acquire_a: assert property (
    (!mode && edge_hit && gap <= acq_win
     && acq == 2'(`PWT_ACQ_EDGES - 2)) |=> mode)
    else $error("external clock not taken after qualified edges");

  sync_loss_a: assert property (
    $fell(mode) |-> $past(gap) >= $past(loss_lim))
    else $error("sync mode dropped before loss timeout");

endmodule

//--- pwt_ext_clk.sv
// Purpose: External sync clock source facing the sync pin
// Assumes: Enable is a bench level
// Notes:   Idles low between bursts, as an unused sync pin would
`timescale 1ns/1ps

module pwt_ext_clk
#(
  parameter realtime HALF_NS = 502.5
)
(
  input  wire logic i_enable,
  output logic      o_clk
);
  // Period of 1005 ns stays in band, within ten percent of the resistor
  // rate, 50% duty, and drifts in phase against the system clock
  always
  begin
    o_clk = 1'b0;
    wait (i_enable === 1'b1);
    while (i_enable === 1'b1)
    begin
      #(HALF_NS) o_clk = 1'b1;
      #(HALF_NS) o_clk = 1'b0;
    end
  end
endmodule

//--- pwt_timing_tb.sv
// Purpose: Self-checking bench for the PWM timing and clock select block
// Assumes: Both duty variants share every input and the oscillator phase
// Notes:   Expected periods and widths are reckoned from the set codes
`timescale 1ns/1ps

module pwt_timing_tb;
  localparam int PW = 10;
  logic                clk;
  logic                rst;
  logic                sync_en;
  logic                trip;
  logic [PW-1:0]       rpin;
  pwt_pkg::pwt_start_t start;
  wire logic           sync_clk;
  wire logic [1:0]     gate;
  wire logic [1:0]     smode;
  wire logic [1:0]     ss;
  int                  n_mismatch = 0;
  int                  total_checks = 0;
  int                  n;
  int                  m;
  int                  ex;
  int                  hi[2] = '{0, 0};
  int                  lo[2] = '{99, 99};
  bit                  mon_en = 1'b0;
  logic [31:0]         rs = 32'h5132;
  int                  tbl[4] = '{50, 100, 1023, 0};
  int                  exp_q[$];

  pwt_ext_clk i_pwt_ext_clk (.i_enable(sync_en), .o_clk(sync_clk));

  pwt_timing #(.FULL_DUTY(1'b1), .PERIOD_W(PW)) i_pwt_timing
  (
    .i_sys_clk(clk), .i_rst(rst), .i_sync_clk(sync_clk), .i_start(start),
    .i_freq_resistor_pin(rpin), .i_peak_trip(trip), .o_gate(gate[0]),
    .o_sync_mode(smode[0]), .o_soft_start(ss[0])
  );

  pwt_timing #(.FULL_DUTY(1'b0), .PERIOD_W(PW)) i_pwt_timing_half
  (
    .i_sys_clk(clk), .i_rst(rst), .i_sync_clk(sync_clk), .i_start(start),
    .i_freq_resistor_pin(rpin), .i_peak_trip(trip), .o_gate(gate[1]),
    .o_sync_mode(smode[1]), .o_soft_start(ss[1])
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    logic [31:0] r;
    r = rs;
    r = r ^ (r << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    rs = r;
    return r;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input int got, input int lo_b, input int hi_b);
    total_checks++;
    if (got < lo_b || got > hi_b)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo_b, hi_b);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cycles until the next rising edge of one gate; bounded
  task automatic rise(input int k, output int c);
    c = 0;
    while (gate[k] !== 1'b0 && c < 3000)
    begin
      @(negedge clk);
      c++;
    end
    while (gate[k] !== 1'b1 && c < 3000)
    begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic hlen(input int k, output int c);
    c = 0;
    while (gate[k] === 1'b1 && c < 3000)
    begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic wait_bit(input int k, input logic v, output int c);
    c = 0;
    while (((k == 0) ? smode[0] : ss[0]) !== v && c < 3000)
    begin
      @(negedge clk);
      c++;
    end
  endtask

  // Every on and off stretch of both variants is measured while running
  always @(negedge clk)
    if (mon_en)
      for (int k = 0; k < 2; k++)
        if (gate[k] === 1'b1)
        begin
          if (lo[k] > 0)
            check_rng(lo[k], 4, 99999);
          lo[k] = 0;
          hi[k]++;
        end
        else
        begin
          if (hi[k] > 0)
            check_rng(hi[k], 12, 99999);
          hi[k] = 0;
          lo[k]++;
        end

  initial
  begin
    #600000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    sync_en = 1'b0;
    trip = 1'b0;
    rpin = PW'(100);
    start = pwt_pkg::pwt_start_t'(6'h00);
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({smode, ss, gate}, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      start = pwt_pkg::pwt_start_t'(6'h3E ^ (6'h01 << k));
      repeat (300) @(negedge clk);
      check({ss, gate}, 32'h0);
    end
    start = pwt_pkg::pwt_start_t'(6'h3E);
    wait_bit(1, 1'b1, n);
    check_rng(n, 2, 6);
    check(ss, 32'h3);
    mon_en = 1'b1;
    // Clamp boundaries, nominal and one random code
    for (int i = 0; i < 4; i++)
    begin
      rpin = (i < 3) ? PW'(tbl[i]) : PW'(100 + xs() % 901);
      ex = (rpin < 100) ? 100 : (rpin > 1000) ? 1000 : int'(rpin);
      exp_q.push_back(ex);
      repeat (3) rise(1, n);
      ex = exp_q.pop_front();
      check_rng(n, ex, ex);
      hlen(1, m);
      check_rng(m, ex / 2 - 1, ex / 2 + 1);
      n = 0;
      repeat (2 * ex)
      begin
        @(negedge clk);
        if (gate[0] !== 1'b1)
          n++;
      end
      check_rng(n, 0, 0);
    end
    rpin = PW'(100);
    trip = 1'b1;
    repeat (3) rise(0, n);
    hlen(0, m);
    check_rng(m, 12, 15);
    // Late turn-off just before the next start delays, not skips, it
    trip = 1'b0;
    repeat (2) rise(1, n);
    repeat (95) @(negedge clk);
    trip = 1'b1;
    hlen(0, m);
    trip = 1'b0;
    rise(0, n);
    check_rng(95 + m + n, 102, 102);
    trip = 1'b1;
    sync_en = 1'b1;
    wait_bit(0, 1'b1, n);
    check_rng(n, 100, 600);
    check(smode, 32'h3);
    repeat (3) rise(0, n);
    check_rng(n, 100, 101);
    @(posedge sync_clk);
    rise(0, n);
    check_rng(n, 3, 6);
    sync_en = 1'b0;
    wait_bit(0, 1'b0, n);
    check_rng(n, 200, 510);
    repeat (3) rise(0, n);
    check_rng(n, 100, 100);
    // Mid-run reset: outputs clear at once and start-up runs again
    mon_en = 1'b0;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    check({smode, ss, gate}, 32'h0);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check({smode, ss, gate}, 32'h0);
    wait_bit(1, 1'b1, n);
    check_rng(n, 1, 1);
    finish_test();
  end
endmodule
